// [rtl/irc_regs.svh]
`ifndef IRC_REGS_SVH
`define IRC_REGS_SVH
// Overview of operation
// - Compare match sets the capture/compare flag; software clears it; unused in PWM.
// - Timer-2 period match sets flag bit 1 until software clears it.
// - Timer-1 overflow sets flag bit 0; only software clears it.
// - Oscillator failure with switch to internal oscillator sets second-flag bit 7.
// - Completed nonvolatile write sets second-flag bit 4; software clears it.
// - Low-voltage detection sets second-flag bit 2 until software clears it.
// - Timer-3 overflow sets second-flag bit 1; bits 6-5, 3, 0 read zero.
// - Without priority levels, peripheral requests need the peripheral enable bit too.
// - First enable register: converter, receive, transmit, capture, timer-2, timer-1 enables.
// - Second enable register: oscillator, write done, low voltage, timer-3; rest zero.
// - Priority bits act only with priority levels on; 1 high, 0 low.
// - Priority registers reset implemented bits to one, positions matching flags.
// - Reset-cause bit 7 turns priority levels on; resets to zero.
// - Reset-cause bits 4 to 0 report the cause of last reset.
// - External pins are edge triggered; select bit chooses rising or falling.
// - A valid pin edge sets its flag; the enable gates the request.
// - External pin requests wake the core; vectoring needs global enable.
// - External 1 and 2 priority from third control; external 0 always high.
// - Timer-0 flag sets on 8-bit wrap, or 16-bit wrap in 16-bit mode.
// - Timer-0 enable is main control bit 5, priority second control bit 2.
// - Port change sets main bit 0; enable bit 3; priority second bit 0.
// - Interrupt entry pushes return counter and shadows working, status, bank registers.
// - With priorities, global gates high and peripheral enable gates low requests.
// - Flags set on their condition regardless of any enable bit.
`define IRC_OFS_MAIN 8'h00
`define IRC_OFS_SECOND 8'h04
`define IRC_OFS_THIRD 8'h08
`define IRC_OFS_FLAGS1 8'h0C
`define IRC_OFS_FLAGS2 8'h10
`define IRC_OFS_EN1 8'h14
`define IRC_OFS_EN2 8'h18
`define IRC_OFS_PRIO1 8'h1C
`define IRC_OFS_PRIO2 8'h20
`define IRC_OFS_CAUSE 8'h24
`define IRC_RST_MAIN 8'h00
`define IRC_RST_SECOND 8'hF5
`define IRC_RST_THIRD 8'hC0
`define IRC_RST_PRIO1 8'h77
`define IRC_RST_PRIO2 8'h96
`define IRC_RST_CAUSE 8'h1C
`define IRC_MASK_SECOND 8'hF5
`define IRC_MASK_THIRD 8'hDB
`define IRC_MASK_1 8'h77
`define IRC_MASK_2 8'h96
`define IRC_MASK_FLAGS1 8'h47
`define IRC_MASK_CAUSE 8'h93
`define IRC_B_GLOBAL 7
`define IRC_B_PERIPH 6
`define IRC_B_T0_EN 5
`define IRC_B_X0_EN 4
`define IRC_B_PB_EN 3
`define IRC_B_T0_FLAG 2
`define IRC_B_X0_FLAG 1
`define IRC_B_PB_FLAG 0
`define IRC_B_EDGE0 6
`define IRC_B_T0_PRIO 2
`define IRC_B_PB_PRIO 0
`define IRC_B_X2_PRIO 7
`define IRC_B_X1_PRIO 6
`define IRC_B_X2_EN 4
`define IRC_B_X1_EN 3
`define IRC_B_X2_FLAG 1
`define IRC_B_X1_FLAG 0
`define IRC_B_CONV 6
`define IRC_B_RX 5
`define IRC_B_TX 4
`define IRC_B_CAPCOMP 2
`define IRC_B_T2 1
`define IRC_B_T1 0
`define IRC_B_OSC 7
`define IRC_B_NV 4
`define IRC_B_LV 2
`define IRC_B_T3 1
`define IRC_B_PRIO_ON 7
`define IRC_PERIPH_SRC 15'h7FE0
`endif

// [rtl/irc_pkg.sv]
package irc_pkg;
    typedef logic [7:0] irc_byte_t;
    typedef enum logic [1:0] {
        IRC_IDLE = 2'b00,
        IRC_ACK = 2'b01
    } irc_bus_t;
endpackage

// [rtl/irc_top.sv]
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "irc_regs.svh"
module irc_top #(
    parameter int PC_W = 21
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [15:0] timer0_value_i,
    input wire logic timer0_16bit_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_match_i,
    input wire logic capcomp_event_i,
    input wire logic capcomp_pwm_mode_i,
    input wire logic conv_done_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    input wire logic timer3_ovf_i,
    input wire logic low_voltage_i,
    input wire logic nv_write_done_i,
    input wire logic osc_fail_i,
    input wire logic internal_oscillator_i,
    input wire logic [2:0] ext_pin_i,
    input wire logic [3:0] portb_hi_i,
    input wire logic portb_read_i,
    input wire logic [4:0] cause_set_i,
    input wire logic [4:0] cause_clr_i,
    input wire logic irq_entry_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire irc_pkg::irc_byte_t working_register_i,
    input wire irc_pkg::irc_byte_t status_i,
    input wire irc_pkg::irc_byte_t bank_select_register_i,
    output logic irq_high_o,
    output logic irq_low_o,
    output logic wake_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_pc_o,
    output var irc_pkg::irc_byte_t shadow_working_o,
    output var irc_pkg::irc_byte_t shadow_status_o,
    output var irc_pkg::irc_byte_t shadow_bank_o
);
    import irc_pkg::*;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Merges a bus write into the writable bits of a register.
    function automatic irc_byte_t wr_upd(input irc_byte_t cur, input irc_byte_t wd,
                                         input irc_byte_t m, input logic hit);
        wr_upd = hit ? ((cur & ~m) | (wd & m)) : cur;
    endfunction

    function automatic logic edge_hit(input logic pin, input logic prev, input logic rise);
        edge_hit = rise ? (pin & ~prev) : (~pin & prev);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    irc_bus_t bus_q, bus_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    irc_byte_t main_q, main_d, second_q, second_d, third_q, third_d;
    irc_byte_t flags1_q, flags1_d, flags2_q, flags2_d;
    irc_byte_t en1_q, en1_d, en2_q, en2_d, prio1_q, prio1_d, prio2_q, prio2_d;
    irc_byte_t cause_q, cause_d;
    logic primed_q, primed_d;
    logic [2:0] pin_prev_q, pin_prev_d;
    logic [3:0] pb_latch_q, pb_latch_d;
    logic [15:0] t0_prev_q, t0_prev_d;
    logic high_q, high_d, low_q, low_d, wake_q, wake_d, push_q, push_d;
    logic [PC_W-1:0] spc_q, spc_d;
    irc_byte_t sw_q, sw_d, ss_q, ss_d, sb_q, sb_d;

    logic [7:0] addr;
    logic wr_hit;
    logic [2:0] ext_edge;
    logic [2:0] edge_rise;
    logic t0_wrap;
    logic pb_mismatch;
    logic [14:0] src_flag, src_en, src_prio, pend;
    logic prio_on, gen, pen;
    irc_byte_t flags1_rd;

    assign addr = {adr_i[7:2], 2'b00};
    assign wr_hit = cyc_i & stb_i & we_i & sel_i[0] & ack_q;
    assign edge_rise = {second_q[`IRC_B_EDGE0-2], second_q[`IRC_B_EDGE0-1], second_q[`IRC_B_EDGE0]};
    assign pb_mismatch = primed_q & (portb_hi_i != pb_latch_q);
    assign prio_on = cause_q[`IRC_B_PRIO_ON];
    assign gen = main_q[`IRC_B_GLOBAL];
    assign pen = main_q[`IRC_B_PERIPH];
    assign flags1_rd = {1'b0, flags1_q[`IRC_B_CONV], serial_rx_full_i, serial_tx_empty_i,
                        1'b0, flags1_q[2:0]};

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            assign ext_edge[gi] = primed_q & edge_hit(ext_pin_i[gi], pin_prev_q[gi], edge_rise[gi]);
        end
    endgenerate

    always_comb begin
        if (timer0_16bit_i) begin
            t0_wrap = primed_q & (t0_prev_q == 16'hFFFF) & (timer0_value_i == 16'h0000);
        end else begin
            t0_wrap = primed_q & (t0_prev_q[7:0] == 8'hFF) & (timer0_value_i[7:0] == 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // Request sources
    // ----------------------------------------------------------------
    // Index: 0 timer-0, 1..4 pin 0, port change, pin 1, pin 2, 5 and up peripherals.
    always_comb begin
        src_flag = {flags2_q[`IRC_B_OSC], flags2_q[`IRC_B_NV], flags2_q[`IRC_B_LV], flags2_q[`IRC_B_T3],
                    flags1_rd[6:4], flags1_q[2:0], third_q[`IRC_B_X2_FLAG], third_q[`IRC_B_X1_FLAG],
                    main_q[`IRC_B_PB_FLAG], main_q[`IRC_B_X0_FLAG], main_q[`IRC_B_T0_FLAG]};
        src_en = {en2_q[`IRC_B_OSC], en2_q[`IRC_B_NV], en2_q[`IRC_B_LV], en2_q[`IRC_B_T3],
                  en1_q[6:4], en1_q[2:0], third_q[`IRC_B_X2_EN], third_q[`IRC_B_X1_EN],
                  main_q[`IRC_B_PB_EN], main_q[`IRC_B_X0_EN], main_q[`IRC_B_T0_EN]};
        src_prio = {prio2_q[`IRC_B_OSC], prio2_q[`IRC_B_NV], prio2_q[`IRC_B_LV], prio2_q[`IRC_B_T3],
                    prio1_q[6:4], prio1_q[2:0], third_q[`IRC_B_X2_PRIO], third_q[`IRC_B_X1_PRIO],
                    second_q[`IRC_B_PB_PRIO], 1'b1, second_q[`IRC_B_T0_PRIO]};
        pend = src_flag & src_en;
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        bus_d = bus_q;
        ack_d = 1'b0;
        rdat_d = rdat_q;
        case (bus_q)
            IRC_IDLE: begin
                if (cyc_i & stb_i) begin
                    bus_d = IRC_ACK;
                    ack_d = 1'b1;
                    case (addr)
                        `IRC_OFS_MAIN: rdat_d = {24'h00_0000, main_q};
                        `IRC_OFS_SECOND: rdat_d = {24'h00_0000, second_q};
                        `IRC_OFS_THIRD: rdat_d = {24'h00_0000, third_q};
                        `IRC_OFS_FLAGS1: rdat_d = {24'h00_0000, flags1_rd};
                        `IRC_OFS_FLAGS2: rdat_d = {24'h00_0000, flags2_q};
                        `IRC_OFS_EN1: rdat_d = {24'h00_0000, en1_q};
                        `IRC_OFS_EN2: rdat_d = {24'h00_0000, en2_q};
                        `IRC_OFS_PRIO1: rdat_d = {24'h00_0000, prio1_q};
                        `IRC_OFS_PRIO2: rdat_d = {24'h00_0000, prio2_q};
                        `IRC_OFS_CAUSE: rdat_d = {24'h00_0000, cause_q};
                        default: rdat_d = 32'h0000_0000;
                    endcase
                end
            end
            IRC_ACK: begin
                bus_d = IRC_IDLE;
            end
            default: begin
                bus_d = IRC_IDLE;
            end
        endcase

        // Software writes first, then hardware sets, so a set in the clearing cycle survives.
        main_d = wr_upd(main_q, dat_i[7:0], 8'hFF, wr_hit && addr == `IRC_OFS_MAIN);
        main_d[`IRC_B_T0_FLAG] = main_d[`IRC_B_T0_FLAG] | t0_wrap;
        main_d[`IRC_B_X0_FLAG] = main_d[`IRC_B_X0_FLAG] | ext_edge[0];
        main_d[`IRC_B_PB_FLAG] = main_d[`IRC_B_PB_FLAG] | pb_mismatch;
        second_d = wr_upd(second_q, dat_i[7:0], `IRC_MASK_SECOND, wr_hit && addr == `IRC_OFS_SECOND);
        third_d = wr_upd(third_q, dat_i[7:0], `IRC_MASK_THIRD, wr_hit && addr == `IRC_OFS_THIRD);
        third_d[`IRC_B_X1_FLAG] = third_d[`IRC_B_X1_FLAG] | ext_edge[1];
        third_d[`IRC_B_X2_FLAG] = third_d[`IRC_B_X2_FLAG] | ext_edge[2];

        flags1_d = wr_upd(flags1_q, dat_i[7:0], `IRC_MASK_FLAGS1, wr_hit && addr == `IRC_OFS_FLAGS1);
        flags1_d[`IRC_B_CONV] = flags1_d[`IRC_B_CONV] | conv_done_i;
        flags1_d[`IRC_B_CAPCOMP] = flags1_d[`IRC_B_CAPCOMP] | (capcomp_event_i & ~capcomp_pwm_mode_i);
        flags1_d[`IRC_B_T2] = flags1_d[`IRC_B_T2] | timer2_match_i;
        flags1_d[`IRC_B_T1] = flags1_d[`IRC_B_T1] | timer1_ovf_i;
        flags2_d = wr_upd(flags2_q, dat_i[7:0], `IRC_MASK_2, wr_hit && addr == `IRC_OFS_FLAGS2);
        flags2_d[`IRC_B_OSC] = flags2_d[`IRC_B_OSC] | (osc_fail_i & internal_oscillator_i);
        flags2_d[`IRC_B_NV] = flags2_d[`IRC_B_NV] | nv_write_done_i;
        flags2_d[`IRC_B_LV] = flags2_d[`IRC_B_LV] | low_voltage_i;
        flags2_d[`IRC_B_T3] = flags2_d[`IRC_B_T3] | timer3_ovf_i;

        en1_d = wr_upd(en1_q, dat_i[7:0], `IRC_MASK_1, wr_hit && addr == `IRC_OFS_EN1);
        en2_d = wr_upd(en2_q, dat_i[7:0], `IRC_MASK_2, wr_hit && addr == `IRC_OFS_EN2);
        prio1_d = wr_upd(prio1_q, dat_i[7:0], `IRC_MASK_1, wr_hit && addr == `IRC_OFS_PRIO1);
        prio2_d = wr_upd(prio2_q, dat_i[7:0], `IRC_MASK_2, wr_hit && addr == `IRC_OFS_PRIO2);
        cause_d = wr_upd(cause_q, dat_i[7:0], `IRC_MASK_CAUSE, wr_hit && addr == `IRC_OFS_CAUSE);
        cause_d[4:0] = (cause_d[4:0] & ~cause_clr_i) | cause_set_i;

        primed_d = 1'b1;
        pin_prev_d = ext_pin_i;
        t0_prev_d = timer0_value_i;
        pb_latch_d = pb_latch_q;
        if (!primed_q || portb_read_i) begin
            pb_latch_d = portb_hi_i;
        end

        // Outputs follow the registered flags one cycle later.
        if (prio_on) begin
            high_d = gen & |(pend & src_prio);
            low_d = gen & pen & |(pend & ~src_prio);
        end else begin
            high_d = gen & (|(pend & ~`IRC_PERIPH_SRC) | (pen & |(pend & `IRC_PERIPH_SRC)));
            low_d = 1'b0;
        end
        wake_d = |pend;

        push_d = irq_entry_i;
        spc_d = spc_q;
        sw_d = sw_q;
        ss_d = ss_q;
        sb_d = sb_q;
        if (irq_entry_i) begin
            spc_d = pc_i;
            sw_d = working_register_i;
            ss_d = status_i;
            sb_d = bank_select_register_i;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= IRC_IDLE;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            main_q <= `IRC_RST_MAIN;
            second_q <= `IRC_RST_SECOND;
            third_q <= `IRC_RST_THIRD;
            flags1_q <= 8'h00;
            flags2_q <= 8'h00;
            en1_q <= 8'h00;
            en2_q <= 8'h00;
            prio1_q <= `IRC_RST_PRIO1;
            prio2_q <= `IRC_RST_PRIO2;
            cause_q <= `IRC_RST_CAUSE;
            primed_q <= 1'b0;
            pin_prev_q <= 3'h0;
            pb_latch_q <= 4'h0;
            t0_prev_q <= 16'h0000;
            high_q <= 1'b0;
            low_q <= 1'b0;
            wake_q <= 1'b0;
            push_q <= 1'b0;
            spc_q <= '0;
            sw_q <= 8'h00;
            ss_q <= 8'h00;
            sb_q <= 8'h00;
        end else begin
            bus_q <= bus_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            main_q <= main_d;
            second_q <= second_d;
            third_q <= third_d;
            flags1_q <= flags1_d;
            flags2_q <= flags2_d;
            en1_q <= en1_d;
            en2_q <= en2_d;
            prio1_q <= prio1_d;
            prio2_q <= prio2_d;
            cause_q <= cause_d;
            primed_q <= primed_d;
            pin_prev_q <= pin_prev_d;
            pb_latch_q <= pb_latch_d;
            t0_prev_q <= t0_prev_d;
            high_q <= high_d;
            low_q <= low_d;
            wake_q <= wake_d;
            push_q <= push_d;
            spc_q <= spc_d;
            sw_q <= sw_d;
            ss_q <= ss_d;
            sb_q <= sb_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign irq_high_o = high_q;
    assign irq_low_o = low_q;
    assign wake_o = wake_q;
    assign stack_push_o = push_q;
    assign stack_pc_o = spc_q;
    assign shadow_working_o = sw_q;
    assign shadow_status_o = ss_q;
    assign shadow_bank_o = sb_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    capcomp_set_a: assert property (capcomp_event_i && !capcomp_pwm_mode_i |=> flags1_q[`IRC_B_CAPCOMP])
        else $error("capture/compare flag not set");
    timer2_set_a: assert property (timer2_match_i |=> flags1_q[`IRC_B_T2] [*2] or (flags1_q[`IRC_B_T2] ##1 1'b1))
        else $error("timer-2 match flag not set");
    timer1_set_a: assert property (timer1_ovf_i |=> flags1_q[`IRC_B_T1])
        else $error("timer-1 overflow flag not set");
    osc_fail_a: assert property (osc_fail_i && internal_oscillator_i |=> flags2_q[`IRC_B_OSC])
        else $error("oscillator fail flag not set");
    nv_done_a: assert property (nv_write_done_i |=> flags2_q[`IRC_B_NV])
        else $error("write done flag not set");
    low_volt_a: assert property (low_voltage_i |=> flags2_q[`IRC_B_LV])
        else $error("low voltage flag not set");
    flags2_holes_a: assert property ((flags2_q & ~`IRC_MASK_2) == 8'h00 && (en2_q & ~`IRC_MASK_2) == 8'h00)
        else $error("unimplemented bits not zero");
    legacy_gate_a: assert property (!prio_on && !pen && (pend & ~`IRC_PERIPH_SRC) == 15'h0000 |=> !irq_high_o)
        else $error("peripheral request passed without peripheral enable");
    prio_reset_a: assert property (disable iff (1'b0) rst_i |=> prio1_q == `IRC_RST_PRIO1
                                   && prio2_q == `IRC_RST_PRIO2 && !prio_on)
        else $error("priority reset values wrong");
    pin0_high_a: assert property (prio_on && gen && main_q[`IRC_B_X0_FLAG] && main_q[`IRC_B_X0_EN]
                                  |=> irq_high_o)
        else $error("external 0 not high priority");
    pin_edge_a: assert property (ext_edge[0] |=> main_q[`IRC_B_X0_FLAG] && !$stable(pin_prev_q[0])
                                 || main_q[`IRC_B_X0_FLAG])
        else $error("pin edge did not set flag");
    wake_pin_a: assert property (|pend[4:1] |=> wake_o)
        else $error("pin request did not wake");
    low_gate_a: assert property (!pen |=> !irq_low_o)
        else $error("low request passed without low enable");
    entry_save_a: assert property (irq_entry_i |=> stack_push_o && stack_pc_o == $past(pc_i)
                                   && shadow_working_o == $past(working_register_i)
                                   && shadow_status_o == $past(status_i)
                                   && shadow_bank_o == $past(bank_select_register_i))
        else $error("context not saved on entry");
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not one cycle");
endmodule
`default_nettype wire

// [tb/irc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Core model: takes a pending request and enters it, at once or after a stall.
// ----------------------------------------
module irc_core_model #(
    parameter int PC_W = 21
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic take_i,
    input wire logic slow_i,
    input wire logic irq_high_i,
    input wire logic irq_low_i,
    output logic irq_entry_o = 1'b0,
    output logic [PC_W-1:0] pc_o = '0,
    output var irc_pkg::irc_byte_t working_register_o,
    output var irc_pkg::irc_byte_t status_o,
    output var irc_pkg::irc_byte_t bank_o
);
    import irc_pkg::*;
    logic [3:0] wait_q = 4'h0;
    logic done_q = 1'b0;
    // Working and status values change every cycle and bank every second cycle, so a late capture cannot pass unseen.
    assign working_register_o = pc_o[7:0];
    assign status_o = ~pc_o[7:0];
    assign bank_o = pc_o[8:1];
    always @(posedge clk_i) begin
        pc_o <= rst_i ? '0 : pc_o + 1'b1;
        irq_entry_o <= !rst_i && take_i && (irq_high_i || irq_low_i) && !done_q
                       && wait_q == (slow_i ? 4'h5 : 4'h0);
        if (rst_i || !take_i) begin
            wait_q <= 4'h0;
            done_q <= 1'b0;
        end else if ((irq_high_i || irq_low_i) && !done_q) begin
            wait_q <= wait_q + 4'h1;
            done_q <= wait_q == (slow_i ? 4'h5 : 4'h0);
        end
    end
endmodule
`default_nettype wire

// [tb/tb_irc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_irc_top;
    import irc_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} irc_row_t;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pwm = 0, iosc = 0, prd = 0, take = 0, slow = 0;
    logic ack_o, hi, lo, wake, push, ent;
    logic [7:0] adr_i = 8'h00, ev = 8'h00, rd;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic [15:0] t0v = 16'h0000;
    logic [3:0] sel = 4'h1, pb = 4'h0;
    logic [2:0] pin = 3'h0;
    logic t16 = 0;
    logic [1:0] ser = 2'b00;
    logic [9:0] cau = 10'h000;
    logic [20:0] pc, spc, pcc;
    irc_byte_t wr_c, st_c, bk_c, sw, ss, sb;
    int num_errors = 0, n_checks = 0, tick = 0, n;
    irc_row_t rows[19] = '{'{0, 8'h00, 8'h00, 8'h00}, '{0, 8'h04, 8'h00, 8'hF5}, '{0, 8'h08, 8'h00, 8'hC0},
        '{0, 8'h0C, 8'h00, 8'h00}, '{0, 8'h10, 8'h00, 8'h00}, '{0, 8'h14, 8'h00, 8'h00}, '{0, 8'h18, 8'h00, 8'h00},
        '{0, 8'h1C, 8'h00, 8'h77}, '{0, 8'h20, 8'h00, 8'h96}, '{0, 8'h24, 8'h00, 8'h1C}, '{1, 8'h14, 8'hFF, 8'h77},
        '{1, 8'h18, 8'hFF, 8'h96}, '{1, 8'h10, 8'hFF, 8'h96}, '{1, 8'h10, 8'h00, 8'h00}, '{1, 8'h24, 8'hFF, 8'h9F},
        '{1, 8'h24, 8'h00, 8'h0C}, '{1, 8'h3C, 8'hFF, 8'h00}, '{1, 8'h1C, 8'h00, 8'h00}, '{1, 8'h1C, 8'hFF, 8'h77}};
    logic [7:0] ea[8] = '{8'h0C, 8'h0C, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0] eb[8] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h02, 8'h04, 8'h10, 8'h80};
    logic [7:0] xs[4] = '{8'hF5, 8'hF5, 8'hB5, 8'hB5};
    logic [7:0] xe[4] = '{8'h12, 8'h10, 8'h10, 8'h12};
    irc_top u_irc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i(sel), .dat_o, .ack_o,
        .timer0_value_i(t0v), .timer0_16bit_i(t16), .timer1_ovf_i(ev[0]), .timer2_match_i(ev[1]),
        .capcomp_event_i(ev[2]), .capcomp_pwm_mode_i(pwm), .conv_done_i(ev[3]), .serial_rx_full_i(ser[1]),
        .serial_tx_empty_i(ser[0]), .timer3_ovf_i(ev[4]), .low_voltage_i(ev[5]), .nv_write_done_i(ev[6]),
        .osc_fail_i(ev[7]), .internal_oscillator_i(iosc), .ext_pin_i(pin), .portb_hi_i(pb), .portb_read_i(prd),
        .cause_set_i(cau[9:5]), .cause_clr_i(cau[4:0]), .irq_entry_i(ent), .pc_i(pc), .working_register_i(wr_c),
        .status_i(st_c), .bank_select_register_i(bk_c), .irq_high_o(hi), .irq_low_o(lo), .wake_o(wake),
        .stack_push_o(push), .stack_pc_o(spc), .shadow_working_o(sw), .shadow_status_o(ss), .shadow_bank_o(sb));
    irc_core_model u_irc_core_model (.clk_i, .rst_i, .take_i(take), .slow_i(slow), .irq_high_i(hi),
        .irq_low_i(lo), .irq_entry_o(ent), .pc_o(pc), .working_register_o(wr_c), .status_o(st_c), .bank_o(bk_c));
    // ----------------------------------------
    // Checks, bus cycles and the closing report.
    // ----------------------------------------
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: byte %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: level %b, expected %b", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= 32'(d);
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, rd);
        chk8(rd, e);
    endtask
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk_i);
        ev <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tick++;
        if (tick == 3000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        wr(8'h14, 8'h01);
        wr(8'h00, 8'h80);
        pulse(0);
        rdc(8'h0C, 8'h01);
        chk1(hi, 1'b0);
        wr(8'h00, 8'hC0);
        repeat (2) @(posedge clk_i);
        chk1(hi, 1'b1);
        wr(8'h0C, 8'h00);
        @(posedge clk_i);
        chk1(hi, 1'b0);
        iosc <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            pulse(k);
            rdc(ea[k], eb[k]);
            wr(ea[k], 8'h00);
        end
        pwm <= 1'b1;
        iosc <= 1'b0;
        pulse(2);
        pulse(7);
        rdc(8'h0C, 8'h00);
        rdc(8'h10, 8'h00);
        ser <= 2'b10;
        rdc(8'h0C, 8'h20);
        ser <= 2'b01;
        rdc(8'h0C, 8'h10);
        ser <= 2'b00;
        wr(8'h24, 8'h80);
        wr(8'h1C, 8'h76);
        pulse(0);
        chk1(lo, 1'b1);
        chk1(hi, 1'b0);
        wr(8'h00, 8'h80);
        repeat (2) @(posedge clk_i);
        chk1(lo, 1'b0);
        wr(8'h1C, 8'h77);
        repeat (2) @(posedge clk_i);
        chk1(hi, 1'b1);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            take <= 1'b1;
            n = 0;
            do @(posedge clk_i); while (ent !== 1'b1 && ++n < 20);
            pcc = pc;
            @(negedge clk_i);
            chk1(push, 1'b1);
            chk1(spc === pcc, 1'b1);
            chk8(sw, pcc[7:0]);
            chk8(ss, ~pcc[7:0]);
            chk8(sb, pcc[8:1]);
            @(posedge clk_i);
            take <= 1'b0;
            @(posedge clk_i);
        end
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'h10);
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, xs[k]);
            pin <= {2'b00, ~k[0]};
            repeat (3) @(posedge clk_i);
            rdc(8'h00, xe[k]);
            chk1(wake, xe[k][1]);
            chk1(hi, 1'b0);
            wr(8'h00, 8'h10);
        end
        wr(8'h04, 8'hF5);
        pin <= 3'h1;
        repeat (3) @(posedge clk_i);
        wr(8'h00, 8'hD2);
        repeat (2) @(posedge clk_i);
        chk1(hi, 1'b1);
        pin <= 3'h7;
        repeat (3) @(posedge clk_i);
        rdc(8'h08, 8'hC3);
        wr(8'h00, 8'h00);
        t0v <= 16'h00FF;
        repeat (2) @(posedge clk_i);
        t0v <= 16'h0100;
        repeat (3) @(posedge clk_i);
        rdc(8'h00, 8'h04);
        wr(8'h04, 8'hF1);
        wr(8'h00, 8'hE4);
        repeat (2) @(posedge clk_i);
        chk1(lo, 1'b1);
        wr(8'h00, 8'h00);
        t16 <= 1'b1;
        t0v <= 16'h01FF;
        repeat (2) @(posedge clk_i);
        t0v <= 16'h0200;
        repeat (3) @(posedge clk_i);
        rdc(8'h00, 8'h00);
        t0v <= 16'hFFFF;
        repeat (2) @(posedge clk_i);
        t0v <= 16'h0000;
        repeat (3) @(posedge clk_i);
        rdc(8'h00, 8'h04);
        pb <= 4'h8;
        repeat (3) @(posedge clk_i);
        wr(8'h00, 8'h00);
        rdc(8'h00, 8'h01);
        prd <= 1'b1;
        @(posedge clk_i);
        prd <= 1'b0;
        wr(8'h00, 8'h00);
        rdc(8'h00, 8'h00);
        sel <= 4'h0;
        wr(8'h14, 8'h00);
        sel <= 4'h1;
        rdc(8'h14, 8'h01);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(8'h24, 8'h1C);
        rdc(8'h1C, 8'h77);
        cau <= 10'h01C;
        @(posedge clk_i);
        cau <= 10'h060;
        @(posedge clk_i);
        cau <= 10'h000;
        rdc(8'h24, 8'h03);
        conclude();
    end
endmodule
`default_nettype wire
